// ===== design/pcdo_divider.sv
// down-counting divider, jam-loadable, emits a pulse on wrap
// assumes: dec is a one-cycle pulse per input rising edge
`timescale 1ns/1ns
module pcdo_divider #(
  parameter int unsigned W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         dec,
  input  wire logic         jam,
  input  wire logic [W-1:0] ratio,
  output logic              tick,
  output logic              pulse
);
  logic [W-1:0] cnt_q;
  logic [3:0]   wid_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (jam) begin
      cnt_q <= ratio;
    end else if (dec) begin
      // reload on one so the period is exactly ratio edges
      cnt_q <= (cnt_q <= W'(1)) ? ratio : cnt_q - W'(1);
    end
  end
  assign tick = dec & (cnt_q <= W'(1)) & ~jam;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wid_q <= '0;
    end else if (jam) begin
      wid_q <= '0;
    end else if (tick) begin
      wid_q <= pcdo_pkg::PULSE_LEN;
    end else if (dec && wid_q != 4'h0) begin
      wid_q <= wid_q - 4'h1;
    end
  end
  assign pulse = (wid_q != 4'h0);
endmodule

// ===== design/pcdo_pkg.sv
// package for the synthesizer configuration and detector output block
// assumes: all logic runs on core_clk, pins are synchronised inside the top
package pcdo_pkg;
  // configuration register bit positions
  localparam int unsigned CFG_POL_BIT  = 7;
  localparam int unsigned CFG_SEL_BIT  = 6;
  localparam int unsigned CFG_LDE_BIT  = 5;
  localparam int unsigned CFG_OSC_HI   = 4;
  localparam int unsigned CFG_OSC_LO   = 2;
  localparam int unsigned CFG_FVE_BIT  = 1;
  localparam int unsigned CFG_FRE_BIT  = 0;
  // power-up value: divide-by-8 reference out, all else cleared
  localparam logic [7:0]  CFG_RESET    = 8'h10;
  // serial frame lengths in clock cycles
  localparam logic [4:0]  LEN_CFG      = 5'h08;
  localparam logic [4:0]  LEN_REF_LONG = 5'h18;
  localparam logic [4:0]  LEN_REF_SHRT = 5'h0f;
  localparam logic [4:0]  LEN_FBK      = 5'h10;
  // divider widths and power-up ratios
  localparam int unsigned REF_W        = 15;
  localparam int unsigned FBK_W        = 16;
  localparam logic [14:0] REF_RESET    = 15'h0005;
  localparam logic [15:0] FBK_RESET    = 16'h0028;
  // divided-output pulse length in input edges
  localparam logic [3:0]  PULSE_LEN    = 4'h4;
  // minimum-width detector pulse when in lock, core cycles
  // two cycles of core_clk give 40 ns, wide enough for the pump drivers to switch
  localparam logic [1:0]  MIN_PULSE_CYC = 2'h2;
endpackage

// ===== design/pcdo_sync.sv
// two flip-flop synchroniser with rising-edge pulse on the synchronised level
// assumes: d comes from outside the core_clk domain
`timescale 1ns/1ns
module pcdo_sync (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic d,
  output logic      level,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
endmodule

// ===== design/pcdo_top.sv
// configuration register, serial framing, dividers and detector outputs
// assumes: serial pins, reference_input and vco_input are asynchronous to core_clk,
// and change far slower than core_clk so that every edge is seen
//
// Notes on behaviour
// - polarity low: feedback leads pulses feedback pump low
// - in lock both pumps pulse low briefly together
// - polarity high inverts single-ended, swaps pump outputs
// - select high: single-ended active, pumps static high
// - select low: pumps active, single-ended high impedance
// - lock output driven only when enabled, else low
// - lock high with narrow low pulses, low on mismatch
// - lock indicator disabled low at power up
// - reference_clock_out codes 0-3: low, /1, /2, /4
// - codes 4,6 give /8; 5,7 give /16; reset /8
// - divided-output enables gate outputs, reset cleared
// - polarity, select, lock enable reset to zero
// - eight clocks store configuration byte only
// - reference divider written by 24 or 15 clocks
// - sixteen clocks store feedback, jam-load both counters
// - single-ended high impedance in lock, pulses otherwise
// - polarity low: single-ended low on lead, high on lag
// - reference counter decrements per reference_input rise
// - feedback counter decrements per vco_input rise
`timescale 1ns/1ns
module pcdo_top (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic serial_clk,
  input  wire logic serial_data,
  input  wire logic serial_enable_n,
  input  wire logic reference_input,
  input  wire logic vco_input,
  output logic      reference_clock_out,
  output logic      reference_divided,
  output logic      feedback_divided,
  output logic      reference_pump_out,
  output logic      feedback_pump_out,
  output logic      single_ended_detector_out,
  output logic      single_ended_detector_oe,
  output logic      lock_indicator,
  output logic [7:0] synth_configuration
);
  logic        sclk_rise;
  logic        sdat_lvl;
  logic        sen_lvl;
  logic        ref_lvl;
  logic        ref_rise;
  logic        vco_rise;
  logic        sen_prev_q;
  logic        frame_end;
  logic [23:0] shift_q;
  logic [4:0]  count_q;
  logic [7:0]  cfg_q;
  logic [14:0] ref_ratio_q;
  logic [15:0] fbk_ratio_q;
  logic        jam_q;
  logic        ref_tick;
  logic        fbk_tick;
  logic        ref_pulse;
  logic        fbk_pulse;
  logic        up_q;
  logic        dn_q;
  logic [1:0]  rst_cnt_q;
  logic        both;
  logic [3:0]  pre_q;
  logic        ref_sel;
  logic        pump_up;
  logic        pump_dn;

  // the serial clock and vco are only used as edges, so their levels stay open
  pcdo_sync u_sclk (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (serial_clk),
    .level    (),
    .rise     (sclk_rise)
  );

  pcdo_sync u_sdat (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (serial_data),
    .level    (sdat_lvl),
    .rise     ()
  );

  pcdo_sync u_sen (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (serial_enable_n),
    .level    (sen_lvl),
    .rise     ()
  );

  pcdo_sync u_ref (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (reference_input),
    .level    (ref_lvl),
    .rise     (ref_rise)
  );

  pcdo_sync u_vco (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (vco_input),
    .level    (),
    .rise     (vco_rise)
  );

  // serial shift in, counted per frame; the frame length picks the register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sen_prev_q <= 1'b1;
    end else begin
      sen_prev_q <= sen_lvl;
    end
  end
  assign frame_end = sen_lvl & ~sen_prev_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= '0;
      count_q <= '0;
    end else if (sen_lvl) begin
      count_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[22:0], sdat_lvl};
      // saturate so over-long frames are never mistaken for a legal length
      count_q <= (count_q == 5'h1f) ? count_q : count_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= pcdo_pkg::CFG_RESET;
    end else if (frame_end && count_q == pcdo_pkg::LEN_CFG) begin
      cfg_q <= shift_q[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_ratio_q <= pcdo_pkg::REF_RESET;
    end else if (frame_end && (count_q == pcdo_pkg::LEN_REF_LONG ||
                               count_q == pcdo_pkg::LEN_REF_SHRT)) begin
      ref_ratio_q <= shift_q[14:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fbk_ratio_q <= pcdo_pkg::FBK_RESET;
      jam_q       <= 1'b0;
    end else begin
      jam_q <= frame_end && count_q == pcdo_pkg::LEN_FBK;
      if (frame_end && count_q == pcdo_pkg::LEN_FBK) begin
        fbk_ratio_q <= shift_q[15:0];
      end
    end
  end

  assign synth_configuration = cfg_q;

  // dividers; jam_q reloads both in the same cycle
  pcdo_divider #(
    .W (pcdo_pkg::REF_W)
  ) u_rdiv (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .dec      (ref_rise),
    .jam      (jam_q),
    .ratio    (ref_ratio_q),
    .tick     (ref_tick),
    .pulse    (ref_pulse)
  );

  pcdo_divider #(
    .W (pcdo_pkg::FBK_W)
  ) u_ndiv (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .dec      (vco_rise),
    .jam      (jam_q),
    .ratio    (fbk_ratio_q),
    .tick     (fbk_tick),
    .pulse    (fbk_pulse)
  );

  // phase/frequency detector: up = feedback edge first (feedback leads)
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if (jam_q || both) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_q | (fbk_tick & ~ref_tick);
      dn_q <= dn_q | (ref_tick & ~fbk_tick);
    end
  end
  // coincident edges or the late edge end the error window
  assign both = (up_q & ref_tick) | (dn_q & fbk_tick) | (fbk_tick & ref_tick);

  // short simultaneous pulse on both pumps when the loop is aligned
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt_q <= '0;
    end else if (both) begin
      rst_cnt_q <= pcdo_pkg::MIN_PULSE_CYC;
    end else if (rst_cnt_q != 2'h0) begin
      rst_cnt_q <= rst_cnt_q - 2'h1;
    end
  end

  assign pump_up = up_q | (rst_cnt_q != 2'h0);
  assign pump_dn = dn_q | (rst_cnt_q != 2'h0);

  // output registers; data outputs all come from flip-flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reference_pump_out <= 1'b1;
      feedback_pump_out  <= 1'b1;
    end else if (cfg_q[pcdo_pkg::CFG_SEL_BIT]) begin
      reference_pump_out <= 1'b1;
      feedback_pump_out  <= 1'b1;
    end else if (cfg_q[pcdo_pkg::CFG_POL_BIT]) begin
      reference_pump_out <= ~pump_up;
      feedback_pump_out  <= ~pump_dn;
    end else begin
      feedback_pump_out  <= ~pump_up;
      reference_pump_out <= ~pump_dn;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      single_ended_detector_out <= 1'b0;
      single_ended_detector_oe  <= 1'b0;
    end else begin
      // driven only during an error window, else released
      single_ended_detector_oe  <= cfg_q[pcdo_pkg::CFG_SEL_BIT] & (up_q ^ dn_q);
      // low on lead with polarity low, inverted by polarity high
      single_ended_detector_out <= dn_q ^ cfg_q[pcdo_pkg::CFG_POL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_indicator <= 1'b0;
    end else begin
      // low during mismatch and during the aligned pulse
      lock_indicator <= cfg_q[pcdo_pkg::CFG_LDE_BIT] & ~(pump_up | pump_dn);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reference_divided <= 1'b0;
      feedback_divided  <= 1'b0;
    end else begin
      reference_divided <= cfg_q[pcdo_pkg::CFG_FRE_BIT] & ref_pulse;
      feedback_divided  <= cfg_q[pcdo_pkg::CFG_FVE_BIT] & fbk_pulse;
    end
  end

  // reference output prescaler counts reference_input rising edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
    end else if (ref_rise) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_comb begin
    unique case (cfg_q[pcdo_pkg::CFG_OSC_HI:pcdo_pkg::CFG_OSC_LO])
      3'h0:        ref_sel = 1'b0;
      3'h1:        ref_sel = ref_lvl;
      3'h2:        ref_sel = pre_q[0];
      3'h3:        ref_sel = pre_q[1];
      3'h4, 3'h6:  ref_sel = pre_q[2];
      3'h5, 3'h7:  ref_sel = pre_q[3];
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reference_clock_out <= 1'b0;
    end else begin
      reference_clock_out <= ref_sel;
    end
  end
endmodule

// ===== tb/pcdo_host.sv
// host model: sends serial frames to the block
// assumes: task called just after a falling core_clk edge
`timescale 1ns/1ns
module pcdo_host (
  input  wire logic core_clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      serial_enable_n
);
  initial begin
    serial_clk      = 1'b0;
    serial_data     = 1'b0;
    serial_enable_n = 1'b1;
  end
  // msb first; length not checked so bad frames can be sent on purpose
  task automatic send(input logic [23:0] v, input int n);
    serial_enable_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = v[i];
      repeat (4) @(negedge core_clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge core_clk);
      serial_clk = 1'b0;
    end
    serial_enable_n = 1'b1;
    // released data line shows the inverse so a stale bit is not trusted
    serial_data = ~serial_data;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ===== tb/pcdo_top_sva.sv
// checker on the ports of pcdo_top
// assumes: one core_clk domain, bound below
`timescale 1ns/1ns
module pcdo_top_sva (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       serial_enable_n,
  input wire logic       reference_clock_out,
  input wire logic       reference_divided,
  input wire logic       feedback_divided,
  input wire logic       reference_pump_out,
  input wire logic       feedback_pump_out,
  input wire logic       single_ended_detector_oe,
  input wire logic       lock_indicator,
  input wire logic [7:0] synth_configuration
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] cfg;
  assign cfg = synth_configuration;
  // eight idle cycles cover the 3-cycle update latency
  sequence s_idle;
    serial_enable_n [*8];
  endsequence
  sequence s_both_low;
    (!reference_pump_out && !feedback_pump_out) [*3];
  endsequence
  AST_RESET_CFG: assert property ($rose(arst_n) |-> cfg == pcdo_pkg::CFG_RESET && !lock_indicator)
    else $error("power-up state wrong");
  // two-cycle settings give the output registers time to follow
  AST_LD_OFF: assert property (!cfg[5] && !$past(cfg[5]) |-> !lock_indicator)
    else $error("lock output not low");
  AST_PUMPS_STATIC: assert property (cfg[6] && $past(cfg[6]) |-> reference_pump_out && feedback_pump_out)
    else $error("pumps not static high");
  AST_SE_OFF: assert property (!cfg[6] && !$past(cfg[6]) |-> !single_ended_detector_oe)
    else $error("single-ended driven");
  AST_REFERENCE_CLOCK_OUT_LOW: assert property (cfg[4:2] == 3'h0 && $past(cfg[4:2]) == 3'h0 |-> !reference_clock_out)
    else $error("reference out not low");
  AST_FV_GATE: assert property (!cfg[1] && !$past(cfg[1]) |-> !feedback_divided)
    else $error("feedback divided not gated");
  AST_FR_GATE: assert property (!cfg[0] && !$past(cfg[0]) |-> !reference_divided)
    else $error("reference divided not gated");
  AST_CFG_HOLD: assert property (s_idle |-> $stable(cfg))
    else $error("configuration changed without a frame");
  AST_PUMP_OVERLAP: assert property (s_both_low |=> reference_pump_out || feedback_pump_out)
    else $error("both pumps low too long");
endmodule
bind pcdo_top pcdo_top_sva u_pcdo_top_sva (.core_clk, .arst_n, .serial_enable_n,
  .reference_clock_out, .reference_divided, .feedback_divided, .reference_pump_out,
  .feedback_pump_out, .single_ended_detector_oe, .lock_indicator, .synth_configuration);

// ===== tb/pcdo_top_tb.sv
// testbench for pcdo_top
// assumes: host model and bound checker compiled alongside
`timescale 1ns/1ns
module pcdo_top_tb;
  logic       core_clk, arst_n, reference_input, vco_q, vco_input, tie, ro_q;
  logic       serial_clk, serial_data, serial_enable_n;
  logic       reference_clock_out, reference_divided, feedback_divided;
  logic       reference_pump_out, feedback_pump_out, lock_indicator;
  logic       single_ended_detector_out, single_ended_detector_oe;
  logic [7:0] synth_configuration;
  int         fails, comparisons, rp, fp, oe, se, lk, ro, dv;
  int         vco_half = 100;
  // tying vco to the reference gives an exact lock
  assign vco_input = tie ? reference_input : vco_q;
  pcdo_host u_pcdo_host (.core_clk, .serial_clk, .serial_data, .serial_enable_n);
  pcdo_top u_pcdo_top (.core_clk, .arst_n, .serial_clk, .serial_data, .serial_enable_n,
    .reference_input, .vco_input, .reference_clock_out, .reference_divided,
    .feedback_divided, .reference_pump_out, .feedback_pump_out,
    .single_ended_detector_out, .single_ended_detector_oe, .lock_indicator,
    .synth_configuration);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    reference_input = 1'b0;
    forever #100 reference_input = ~reference_input;
  end
  initial begin
    vco_q = 1'b0;
    forever #(vco_half) vco_q = ~vco_q;
  end
  always @(posedge core_clk) begin
    ro_q <= reference_clock_out;
    ro += int'(reference_clock_out && !ro_q);
    rp += int'(!reference_pump_out && feedback_pump_out);
    fp += int'(reference_pump_out && !feedback_pump_out);
    oe += int'(single_ended_detector_oe === 1'b1);
    se += int'(single_ended_detector_oe && single_ended_detector_out);
    lk += int'(lock_indicator === 1'b1);
    dv += int'(reference_divided && feedback_divided);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] c, input int n);
    u_pcdo_host.send(24'(c), 8);
    repeat (200) @(negedge core_clk);
    {rp, fp, oe, se, lk, ro, dv} = '0;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_reset;
    chk(32'(synth_configuration), 32'h10);
    chk(32'(lock_indicator), 32'h0);
    chk(32'({reference_divided, feedback_divided}), 32'h0);
  endtask
  task automatic t_frames;
    u_pcdo_host.send(24'ha5, 8);
    chk(32'(synth_configuration), 32'ha5);
    u_pcdo_host.send(24'h15a, 9);
    chk(32'(synth_configuration), 32'ha5);
    u_pcdo_host.send(24'h28, 16);
    chk(32'(synth_configuration), 32'ha5);
  endtask
  task automatic t_reference_clock_out;
    int e_tab[8] = '{0, 64, 32, 16, 8, 4, 8, 4};
    int e;
    for (int k = 0; k < 8; k++) begin
      run(8'(k << 2), 640);
      e = e_tab[k];
      chk(32'(e == 0 ? ro == 0 : ro >= e - 1 && ro <= e + 1), 32'h1);
    end
  endtask
  task automatic t_detect;
    u_pcdo_host.send(24'd40, 16);
    run(8'h33, 800);
    chk(32'(rp > 0 && fp == 0 && oe == 0), 32'h1);
    run(8'hb3, 800);
    chk(32'(fp > 0 && rp == 0), 32'h1);
    run(8'h73, 800);
    chk(32'(se > 0 && rp + fp == 0), 32'h1);
    run(8'hf3, 800);
    chk(32'(oe > 0 && se == 0), 32'h1);
    vco_half = 60;
    u_pcdo_host.send(24'd5, 16);
    run(8'h33, 800);
    chk(32'(fp > 0 && rp == 0), 32'h1);
    run(8'h73, 800);
    chk(32'(oe > 0 && se == 0), 32'h1);
  endtask
  task automatic t_lock;
    tie = 1'b1;
    u_pcdo_host.send(24'd5, 16);
    run(8'h73, 800);
    chk(32'(oe), 32'h0);
    run(8'h33, 800);
    chk(32'(rp + fp == 0 && lk > 0 && dv > 0), 32'h1);
    u_pcdo_host.send(24'd10, 24);
    u_pcdo_host.send(24'd10, 16);
    run(8'h33, 800);
    chk(32'(rp + fp), 32'h0);
    u_pcdo_host.send(24'd5, 15);
    run(8'h13, 800);
    chk(32'(rp > 0 && fp == 0 && lk == 0), 32'h1);
  endtask
  task automatic conclude;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    tie    = 1'b0;
    ro_q   = 1'b0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_frames();
    t_reference_clock_out();
    t_detect();
    t_lock();
    conclude();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    conclude();
  end
endmodule
